/* design/osc_cal_control.sv */
// Register file and successive-approximation engine for oscillator trim calibration.
`include "vco_cal_regs.svh"
`default_nettype none
module osc_cal_engine (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire vco_cal_pkg::reg_req_t req,
  input wire logic freq_high,
  output logic [7:0] rdata,
  output logic [6:0] osc_trim_code,
  output logic synth_reset_hold,
  output logic osc_cal_complete,
  output logic cal_busy
);
  logic hold_ff;
  logic nxt_hold;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [6:0] trim_ff;
  logic [6:0] nxt_trim;
  logic [6:0] probe_ff;
  logic [6:0] nxt_probe;
  logic done_ff;
  logic nxt_done;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic busy_ff;
  logic nxt_busy;
  logic fhi_s1_ff;
  logic fhi_s2_ff;
  logic fhi_s3_ff;
  logic fhi_ff;
  logic nxt_fhi;
  vco_cal_pkg::cal_state_t state_ff;
  vco_cal_pkg::cal_state_t nxt_state;
  logic settle_load;
  logic settle_expired;
  logic hold_release;
  logic cal_en;
  logic [11:0] settle_seen_ff;
  logic [11:0] nxt_settle_seen;

  assign cal_en = ctrl_ff[`BIT_CAL_EN];
  // Only a write of zero while the hold bit is set starts work; rewriting zero does nothing.
  assign hold_release = req.wr && (req.addr == `ADDR_SYNTH_RESET) &&
                        !req.wdata[`BIT_HOLD] && hold_ff;

  // The timer stays a separate module so its width can follow the longest settling code.
  settle_timer u_settle (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(settle_load),
    .sel(ctrl_ff[`STL_HI:`STL_LO]),
    .expired(settle_expired)
  );

  // The comparator output comes from the analog loop, so it is synchronised first.
  always_comb
  begin
    nxt_fhi = fhi_ff;
    if (fhi_s2_ff == fhi_s3_ff)
      nxt_fhi = fhi_s3_ff;
  end

  // Only the second stage reads the first, so nothing acts on a value that may be metastable.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fhi_s1_ff <= 1'b0;
      fhi_s2_ff <= 1'b0;
      fhi_s3_ff <= 1'b0;
      fhi_ff <= 1'b0;
    end
    else if (ce)
    begin
      fhi_s1_ff <= freq_high;
      fhi_s2_ff <= fhi_s1_ff;
      fhi_s3_ff <= fhi_s2_ff;
      fhi_ff <= nxt_fhi;
    end
  end

  // Register writes and the engine share the trim register; the engine wins while busy.
  always_comb
  begin
    nxt_hold = hold_ff;
    nxt_ctrl = ctrl_ff;
    nxt_trim = trim_ff;
    nxt_probe = probe_ff;
    nxt_done = done_ff;
    nxt_state = state_ff;
    nxt_busy = busy_ff;
    nxt_rdata = 8'h00;
    settle_load = 1'b0;
    if (req.wr)
    begin
      unique case (req.addr)
        `ADDR_SYNTH_RESET: nxt_hold = req.wdata[`BIT_HOLD]; // [R6]
        `ADDR_CAL_CTRL: nxt_ctrl = req.wdata; // [R5] [R8]
        `ADDR_TRIM: if (!busy_ff) nxt_trim = req.wdata[`TRIM_HI:0]; // [R1] [R2]
        default: ;
      endcase
    end
    if (req.rd)
    begin
      unique case (req.addr)
        `ADDR_SYNTH_RESET: nxt_rdata = {7'h00, hold_ff};
        `ADDR_CAL_CTRL: nxt_rdata = ctrl_ff;
        `ADDR_TRIM: nxt_rdata = {1'b0, trim_ff}; // [R2]
        `ADDR_CAL_STATUS: nxt_rdata = {7'h00, done_ff}; // [R10] [R12]
        default: nxt_rdata = 8'h00;
      endcase
    end
    unique case (state_ff)
      vco_cal_pkg::ST_IDLE:
      begin
        if (hold_release)
        begin
          if (cal_en)
          begin
            // Start with the MSB probe at mid-scale.
            nxt_trim = `TRIM_MID; // [R6] [R7]
            nxt_probe = `TRIM_MID;
            nxt_busy = 1'b1;
            settle_load = 1'b1;
            nxt_state = vco_cal_pkg::ST_SETTLE;
          end
          else
          begin
            nxt_done = 1'b1; // [R11]
            nxt_state = vco_cal_pkg::ST_DONE;
          end
        end
      end
      vco_cal_pkg::ST_SETTLE:
      begin
        if (settle_expired)
          nxt_state = vco_cal_pkg::ST_JUDGE; // [R17]
      end
      vco_cal_pkg::ST_JUDGE:
      begin
        // Frequency too high means the probed bit is dropped again.
        if (fhi_ff)
          nxt_trim = trim_ff & ~probe_ff; // [R7]
        if (probe_ff == 7'h01)
        begin
          if (fhi_ff)
            nxt_trim = trim_ff & ~probe_ff;
          nxt_busy = 1'b0;
          nxt_done = 1'b1; // [R10]
          nxt_state = vco_cal_pkg::ST_DONE;
        end
        else
        begin
          nxt_trim = (fhi_ff ? (trim_ff & ~probe_ff) : trim_ff) | (probe_ff >> 1);
          nxt_probe = probe_ff >> 1;
          settle_load = 1'b1;
          nxt_state = vco_cal_pkg::ST_SETTLE;
        end
      end
      vco_cal_pkg::ST_DONE: ;
      default: nxt_state = vco_cal_pkg::ST_IDLE;
    endcase
    // Setting the hold bit aborts whatever the engine was doing.
    if (nxt_hold)
    begin
      nxt_done = 1'b0; // [R16]
      nxt_busy = 1'b0;
      nxt_state = vco_cal_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Only the hold bit of the reset register is stored; the rest reads as zero.
      hold_ff <= 1'(`SYNTH_RESET_RST); // [R15]
      ctrl_ff <= `CAL_CTRL_RST; // [R14]
      trim_ff <= `TRIM_RST;
      probe_ff <= 7'h00;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
      rdata_ff <= 8'h00;
      state_ff <= vco_cal_pkg::ST_IDLE;
    end
    else if (ce)
    begin
      hold_ff <= nxt_hold;
      ctrl_ff <= nxt_ctrl;
      trim_ff <= nxt_trim;
      probe_ff <= nxt_probe;
      done_ff <= nxt_done;
      busy_ff <= nxt_busy;
      rdata_ff <= nxt_rdata;
      state_ff <= nxt_state;
    end
  end

  assign rdata = rdata_ff;
  assign osc_trim_code = trim_ff;
  assign synth_reset_hold = hold_ff;
  assign osc_cal_complete = done_ff;
  assign cal_busy = busy_ff;

  // Checks on the abort path, the register port, the start and skip paths, the comparator synchroniser and the clock enable.
  chk_hold_clears_done: assert property (@(posedge clk) disable iff (rst) // [R16]
    hold_ff |-> !done_ff)
    else $error("done high while hold set");
  chk_skip_sets_done: assert property (@(posedge clk) disable iff (rst) // [R11]
    (ce && hold_release && !cal_en && state_ff == vco_cal_pkg::ST_IDLE) |=> done_ff)
    else $error("skip did not set done");
  chk_start_sets_busy: assert property (@(posedge clk) disable iff (rst) // [R6]
    (ce && hold_release && cal_en && state_ff == vco_cal_pkg::ST_IDLE) |=>
      (busy_ff && trim_ff == `TRIM_MID))
    else $error("start did not load mid trim");
  chk_no_start_held: assert property (@(posedge clk) disable iff (rst) // [R6]
    (hold_ff && $past(hold_ff)) |-> !busy_ff)
    else $error("engine ran while held");
  chk_status_upper: assert property (@(posedge clk) disable iff (rst) // [R12]
    ($past(req.rd) && $past(req.addr) == `ADDR_CAL_STATUS && $past(ce)) |->
      rdata_ff[7:1] == 7'h00)
    else $error("status upper bits nonzero");
  chk_busy_not_done: assert property (@(posedge clk) disable iff (rst) // [R10]
    busy_ff |-> !done_ff)
    else $error("busy and done together");
  chk_trim_frozen: assert property (@(posedge clk) disable iff (rst) // [R2]
    (ce && done_ff && !req.wr) |=> $stable(trim_ff))
    else $error("trim moved after done");
  chk_ctrl_write: assert property (@(posedge clk) disable iff (rst) // [R5]
    (ce && req.wr && req.addr == `ADDR_CAL_CTRL) |=> ctrl_ff == $past(req.wdata))
    else $error("control write lost");
  chk_hold_idle: assert property (@(posedge clk) disable iff (rst) // [R16]
    hold_ff |-> (state_ff == vco_cal_pkg::ST_IDLE && !busy_ff))
    else $error("engine active while hold set");
  chk_trim_write_taken: assert property (@(posedge clk) disable iff (rst) // [R2]
    (ce && !busy_ff && req.wr && req.addr == `ADDR_TRIM) |=>
      trim_ff == $past(req.wdata[`TRIM_HI:0]))
    else $error("trim write lost while idle");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    (ce && !req.rd) |=> rdata_ff == 8'h00)
    else $error("read data not cleared");
  chk_sync_agree: assert property (@(posedge clk) disable iff (rst)
    (ce && fhi_s2_ff != fhi_s3_ff) |=> $stable(fhi_ff))
    else $error("comparator taken before stages agreed");
  chk_ce_freezes: assert property (@(posedge clk) disable iff (rst)
    !ce |=> ($stable(trim_ff) && $stable(ctrl_ff) && $stable(hold_ff) && $stable(done_ff)))
    else $error("state moved while clock enable low");

  // Shadow count of the cycles spent settling, kept apart from the timer so that a wrong
  // load value or a wrapped count shows up as a mismatch rather than a silent short wait.
  always_comb
  begin
    nxt_settle_seen = 12'h000;
    if (state_ff == vco_cal_pkg::ST_SETTLE)
      nxt_settle_seen = settle_seen_ff + 12'h001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      settle_seen_ff <= 12'h000;
    else if (ce)
      settle_seen_ff <= nxt_settle_seen;
  end

  // One calibration is a start, then a settle and a judge per trim bit, then done.
  sequence seq_cal_start;
    ce && hold_release && cal_en && state_ff == vco_cal_pkg::ST_IDLE;
  endsequence
  sequence seq_mid_judge;
    ce && state_ff == vco_cal_pkg::ST_JUDGE && probe_ff != 7'h01 && !nxt_hold;
  endsequence
  sequence seq_last_judge;
    ce && state_ff == vco_cal_pkg::ST_JUDGE && probe_ff == 7'h01 && !nxt_hold;
  endsequence

  // Each step of the sequence above is checked on its own edge.
  chk_first_settle: assert property (@(posedge clk) disable iff (rst) // [R7]
    seq_cal_start |=> (state_ff == vco_cal_pkg::ST_SETTLE && probe_ff == `TRIM_MID))
    else $error("start did not enter settle");
  chk_settle_length: assert property (@(posedge clk) disable iff (rst) // [R17]
    (state_ff == vco_cal_pkg::ST_JUDGE) |->
      settle_seen_ff == (12'(`SETTLE_BASE_CYC) << ctrl_ff[`STL_HI:`STL_LO]))
    else $error("settle wait has wrong length");
  chk_judge_single: assert property (@(posedge clk) disable iff (rst) // [R7]
    (ce && state_ff == vco_cal_pkg::ST_JUDGE) |=> state_ff != vco_cal_pkg::ST_JUDGE)
    else $error("judge lasted more than one cycle");
  chk_probe_halves: assert property (@(posedge clk) disable iff (rst) // [R7]
    seq_mid_judge |=>
      (state_ff == vco_cal_pkg::ST_SETTLE && probe_ff == ($past(probe_ff) >> 1)))
    else $error("probe did not move to the next bit");
  chk_lsb_finishes: assert property (@(posedge clk) disable iff (rst) // [R10]
    seq_last_judge |=> (done_ff && !busy_ff && state_ff == vco_cal_pkg::ST_DONE))
    else $error("engine did not finish after the last bit");
endmodule
`default_nettype wire

/* design/vco_cal_regs.svh */
// Register offsets, field positions, reset values and timing counts for the oscillator calibration block.
// Operation
// R1: The trim register holds a seven-bit oscillator trim code in bits 6 to 0, and that code sets the oscillator frequency.
// R2: Once calibration has run, the chosen trim code reads back from the trim register, and software may write it back on later power-ups.
// R3: Software neither reads nor writes the trim register while calibration is enabled and done is still low.
// R4: Software sets the synthesizer reset bit before programming the synthesizer and clears it when programming is finished.
// R5: Bit 0 of the calibration control register enables the calibration engine.
// R6: With calibration enabled, the sequence starts when the synthesizer reset bit is written to zero, and not before.
// R7: The engine adjusts the trim code by itself until the oscillator frequency is centred.
// R8: The settling field in bits 6 to 4 resets to 4 and sets the wait after each trim change, with larger codes giving longer waits.
// R9: Software changes the calibration control register only while the synthesizer reset bit is one.
// R10: Done, bit 0 of the read-only status register, goes to one when calibration has finished.
// R11: With calibration disabled, done still reads one to show that calibration was skipped.
// R12: The status register is read-only, and its bits 7 to 1 read as zero.
// R13: Software writes reserved bits only with zero.
// R14: After reset the calibration control register holds 0x40.
// R15: After reset the synthesizer reset register holds 0x00.
// R16: Setting the synthesizer reset bit aborts calibration and clears done until a new calibration or skip completes.
// R17: Each settling code maps to a fixed number of cycles, and the engine waits that many cycles after every trim update; the last LSB drop gets no wait.
`ifndef VCO_CAL_REGS_SVH
`define VCO_CAL_REGS_SVH
`define ADDR_TRIM 8'h59
`define ADDR_SYNTH_RESET 8'h5c
`define ADDR_CAL_CTRL 8'h5d
`define ADDR_CAL_STATUS 8'h5e
`define SYNTH_RESET_RST 8'h00
`define CAL_CTRL_RST 8'h40
`define TRIM_RST 7'h00
`define TRIM_MID 7'h40
`define BIT_HOLD 0
`define BIT_CAL_EN 0
`define BIT_DONE 0
`define STL_HI 6
`define STL_LO 4
`define TRIM_HI 6
`define SETTLE_BASE_NS 1600
`define CLK_PERIOD_NS 100
`define SETTLE_BASE_CYC ((`SETTLE_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* design/vco_cal_pkg.sv */
// Types shared by the oscillator calibration block.
`default_nettype none
package vco_cal_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_JUDGE = 3'b010,
    ST_DONE = 3'b011
  } cal_state_t;
endpackage
`default_nettype wire

/* design/settle_timer.sv */
// Down-counter that times the settling wait for one settling code.
`include "vco_cal_regs.svh"
`default_nettype none
module settle_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [2:0] sel,
  output logic expired
);
  // Twelve bits hold the longest wait of code 7 without wrapping it to zero.
  logic [11:0] cnt_ff;
  logic [11:0] nxt_cnt;

  // The wait doubles per code step, so larger codes are strictly longer.
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (load)
      nxt_cnt = 12'(`SETTLE_BASE_CYC) << sel; // [R8] [R17]
    else if (cnt_ff != 12'h000)
      nxt_cnt = cnt_ff - 12'h001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_ff <= 12'h000;
    else if (ce)
      cnt_ff <= nxt_cnt;
  end

  assign expired = (cnt_ff == 12'h001);
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the oscillator calibration register block.
`include "vco_cal_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] addr; logic [7:0] wd; logic [7:0] exp;} row_t;
  logic clk;
  logic rst;
  logic ce;
  logic freq_high;
  logic synth_reset_hold;
  logic osc_cal_complete;
  logic cal_busy;
  vco_cal_pkg::reg_req_t req;
  logic [7:0] rdata;
  logic [7:0] rd_val;
  logic [6:0] osc_trim_code;
  logic [6:0] target;
  int error_cnt;
  int n_tests;
  int c0;
  int c1;
  int c2;
  row_t rows [5];

  osc_cal_engine DUT (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .req(req),
    .freq_high(freq_high),
    .rdata(rdata),
    .osc_trim_code(osc_trim_code),
    .synth_reset_hold(synth_reset_hold),
    .osc_cal_complete(osc_cal_complete),
    .cal_busy(cal_busy)
  );

  // The comparator follows the trim one half cycle later, so it is steady long before each judge.
  always @(negedge clk)
    freq_high <= osc_trim_code > target;

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
    rd_val = rdata;
  endtask

  task automatic wait_done(output int cyc);
    cyc = 0;
    while (osc_cal_complete !== 1'b1 && cyc < 20000)
    begin
      @(negedge clk);
      cyc++;
    end
    if (cyc >= 20000)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
    end
  endtask

  task automatic run_cal(input logic [2:0] code, input logic [6:0] tgt, output int cyc);
    target = tgt;
    reg_wr(`ADDR_SYNTH_RESET, 8'h01);
    check({6'h00, synth_reset_hold, osc_cal_complete}, 8'h02);
    reg_wr(`ADDR_CAL_CTRL, {1'b0, code, 4'h1});
    check({7'h00, cal_busy}, 8'h00);
    reg_wr(`ADDR_SYNTH_RESET, 8'h00);
    check({6'h00, synth_reset_hold, cal_busy}, 8'h01);
    wait_done(cyc);
    check({1'b0, osc_trim_code}, {1'b0, tgt});
    reg_rd(`ADDR_CAL_STATUS);
    check(rd_val, 8'h01);
    reg_rd(`ADDR_TRIM);
    check(rd_val, {1'b0, tgt});
    $display("calibration with settle code %0d took %0d cycles", code, cyc);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    target = 7'h00;
    freq_high = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    rows[0] = '{8'h5c, 8'h01, 8'h01};
    rows[1] = '{8'h5d, 8'h31, 8'h31};
    rows[2] = '{8'h59, 8'h2a, 8'h2a};
    rows[3] = '{8'h5e, 8'hff, 8'h00};
    rows[4] = '{8'h60, 8'h55, 8'h00};
    repeat (20) @(negedge clk);
    rst <= 1'b0;
    reg_rd(`ADDR_CAL_CTRL);
    check(rd_val, 8'h40);
    reg_rd(`ADDR_SYNTH_RESET);
    check(rd_val, 8'h00);
    reg_rd(`ADDR_CAL_STATUS);
    check(rd_val, 8'h00);
    $display("reset values done");
    foreach (rows[i])
    begin
      reg_wr(rows[i].addr, rows[i].wd);
      reg_rd(rows[i].addr);
      check(rd_val, rows[i].exp);
    end
    check({1'b0, osc_trim_code}, 8'h2a);
    $display("register table done");
    reg_wr(`ADDR_CAL_CTRL, 8'h40);
    reg_wr(`ADDR_SYNTH_RESET, 8'h00);
    reg_rd(`ADDR_CAL_STATUS);
    check(rd_val, 8'h01);
    $display("skipped calibration done");
    run_cal(3'h0, 7'h55, c0);
    run_cal(3'h1, 7'h2a, c1);
    check({7'h00, c1 > c0}, 8'h01);
    check({7'h00, c0 >= 112}, 8'h01);
    run_cal(3'h7, 7'h15, c2);
    check({7'h00, c2 > c1}, 8'h01);
    check({7'h00, c2 >= 7 * (`SETTLE_BASE_CYC << 7)}, 8'h01);
    reg_wr(`ADDR_TRIM, 8'h13);
    reg_rd(`ADDR_TRIM);
    check(rd_val, 8'h13);
    $display("trim write back done");
    ce <= 1'b0;
    reg_wr(`ADDR_TRIM, 8'h7f);
    ce <= 1'b1;
    reg_rd(`ADDR_TRIM);
    check(rd_val, 8'h13);
    $display("clock enable freeze done");
    target = 7'h40;
    reg_wr(`ADDR_SYNTH_RESET, 8'h01);
    reg_wr(`ADDR_CAL_CTRL, 8'h01);
    reg_wr(`ADDR_SYNTH_RESET, 8'h00);
    repeat (10) @(negedge clk);
    reg_wr(`ADDR_SYNTH_RESET, 8'h01);
    check({6'h00, cal_busy, osc_cal_complete}, 8'h00);
    repeat (300) @(negedge clk);
    check({7'h00, osc_cal_complete}, 8'h00);
    $display("abort done");
    reg_wr(`ADDR_SYNTH_RESET, 8'h00);
    check({7'h00, cal_busy}, 8'h01);
    repeat (5) @(negedge clk);
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    rst <= 1'b0;
    reg_rd(`ADDR_CAL_CTRL);
    check(rd_val, 8'h40);
    reg_rd(`ADDR_SYNTH_RESET);
    check(rd_val, 8'h00);
    reg_rd(`ADDR_CAL_STATUS);
    check(rd_val, 8'h00);
    check({cal_busy, osc_trim_code}, 8'h00);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
